// *** inc/asm_pkg.sv ***
// Purpose: constants shared by the alarm status and mask block
// Assumes: 8-bit registers on a plain address/strobe port
// Notes: offsets are byte addresses of the register port
package asm_pkg;
  // register offsets
  localparam logic [7:0] ADDR_ALARM_STATUS = 8'h02;
  localparam logic [7:0] ADDR_ALARM_MASK = 8'h16;
  localparam logic [7:0] ADDR_CONFIG = 8'hBF;
  // status, mask and config bit positions
  localparam int BIT_BUSY = 7;
  localparam int BIT_LOCAL_HIGH = 6;
  localparam int BIT_UNUSED_HI = 5;
  localparam int BIT_REMOTE_HIGH = 4;
  localparam int BIT_REMOTE_LOW = 3;
  localparam int BIT_DIODE_FAULT = 2;
  localparam int BIT_CRIT = 1;
  localparam int BIT_TACH = 0;
  localparam int BIT_COMPARATOR = 0;
  // alarms that may raise irq; all but tach may also reach the alert pin
  localparam logic [7:0] ALERT_CAPABLE = 8'h5B;
  // reset values, forced mask bits and synchroniser depth
  localparam logic [7:0] MASK_RESET = 8'hA4;
  localparam logic [7:0] MASK_FORCED_ONE = 8'hA4;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam int SYNC_STAGES = 3;
endpackage : asm_pkg

// *** rtl/asm_sync.sv ***
// Purpose: three-stage synchroniser, change taken when stages two and three agree
// Assumes: input is asynchronous to clk
// Notes: first stage is read only by the second
`timescale 1ns/1ps
module asm_sync (
  input wire logic clk,
  input wire logic reset,
  input wire logic async_in,
  output logic sync_out
);
  logic [2:0] stage_r; // shift chain
  // sample the pin
  always_ff @(posedge clk) begin
    if (reset) begin
      stage_r <= 3'h0;
    end else begin
      stage_r <= {stage_r[1:0], async_in};
    end
  end
  // accept new level only once two later stages agree
  always_ff @(posedge clk) begin
    if (reset) begin
      sync_out <= 1'b0;
    end else if (stage_r[1] == stage_r[2]) begin
      sync_out <= stage_r[2];
    end
  end
endmodule : asm_sync

// *** rtl/asm_cond.sv ***
// Purpose: strict comparisons that form the alarm conditions
// Assumes: temperatures two's complement, tach count unsigned
// Notes: equality never raises an alarm
`timescale 1ns/1ps
module asm_cond (
  input wire logic signed [7:0] local_temp,
  input wire logic signed [7:0] local_high,
  input wire logic signed [10:0] remote_temp,
  input wire logic signed [10:0] remote_high,
  input wire logic signed [10:0] remote_low,
  input wire logic signed [7:0] critical_limit,
  input wire logic [15:0] tach_count,
  input wire logic [15:0] tach_limit,
  output logic [4:0] cond
);
  logic signed [10:0] crit_ext; // limit in remote format
  assign crit_ext = {critical_limit, 3'h0};
  assign cond[4] = local_temp > local_high;
  assign cond[3] = remote_temp > remote_high;
  assign cond[2] = remote_temp < remote_low;
  assign cond[1] = remote_temp > crit_ext;
  assign cond[0] = tach_count > tach_limit;
endmodule : asm_cond

// *** rtl/asm_alert_status_mask.sv ***
// Purpose: alarm status and mask logic with alert output
// Assumes: conditions come from same-clock compare logic; diode fault from a pin
// Notes: status clears on read only where the condition has gone
`timescale 1ns/1ps
module asm_alert_status_mask (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic busy,
  input wire logic diode_fault_pin,
  input wire logic pin_is_tach,
  input wire logic signed [7:0] local_temp,
  input wire logic signed [7:0] local_high,
  input wire logic signed [10:0] remote_temp,
  input wire logic signed [10:0] remote_high,
  input wire logic signed [10:0] remote_low,
  input wire logic signed [7:0] critical_limit,
  input wire logic [15:0] tach_count,
  input wire logic [15:0] tach_limit,
  output logic alert_n_o,
  output logic alert_n_oe,
  output logic irq
);
  logic [4:0] cond; // compare results
  logic diode_fault; // synchronised fault level
  logic [7:0] live; // live conditions at status positions
  logic [7:0] status_r; // sticky alarm bits
  logic [7:0] mask_r; // alarm mask
  logic [7:0] config_r; // configuration, bit 0 comparator mode
  logic [7:0] status_view; // value a read returns
  logic [7:0] mask_view; // mask as read
  logic [7:0] reg_rdata_nxt; // next read data
  logic rd_status; // status read this cycle
  logic [7:0] alert_src; // alarms driving the pin
  logic alert_nxt; // pin asserted next cycle

  asm_cond u_cond (
    .local_temp(local_temp),
    .local_high(local_high),
    .remote_temp(remote_temp),
    .remote_high(remote_high),
    .remote_low(remote_low),
    .critical_limit(critical_limit),
    .tach_count(tach_count),
    .tach_limit(tach_limit),
    .cond(cond)
  );

  // fault comes from the analog front end, so it is synchronised
  asm_sync u_sync (
    .clk(clk),
    .reset(reset),
    .async_in(diode_fault_pin),
    .sync_out(diode_fault)
  );

  // live conditions laid out as the status register
  always_comb begin
    live = 8'h00;
    live[asm_pkg::BIT_LOCAL_HIGH] = cond[4];
    live[asm_pkg::BIT_REMOTE_HIGH] = cond[3];
    live[asm_pkg::BIT_REMOTE_LOW] = cond[2];
    live[asm_pkg::BIT_DIODE_FAULT] = diode_fault;
    live[asm_pkg::BIT_CRIT] = cond[1];
    live[asm_pkg::BIT_TACH] = cond[0];
  end

  assign rd_status = reg_rd && (reg_addr == asm_pkg::ADDR_ALARM_STATUS);

  // sticky bits: a live condition always wins over the read clear
  always_ff @(posedge clk) begin
    if (reset) begin
      status_r <= 8'h00;
    end else if (rd_status) begin
      status_r <= live;
    end else begin
      status_r <= status_r | live;
    end
  end

  // busy is live, bit 5 forced low
  always_comb begin
    status_view = status_r;
    status_view[asm_pkg::BIT_BUSY] = busy;
    status_view[asm_pkg::BIT_UNUSED_HI] = 1'b0;
  end

  assign mask_view = mask_r | asm_pkg::MASK_FORCED_ONE;

  // mask and configuration writes
  always_ff @(posedge clk) begin
    if (reset) begin
      mask_r <= asm_pkg::MASK_RESET;
      config_r <= asm_pkg::CONFIG_RESET;
    end else if (reg_wr) begin
      if (reg_addr == asm_pkg::ADDR_ALARM_MASK) begin
        mask_r <= reg_wdata | asm_pkg::MASK_FORCED_ONE;
      end
      if (reg_addr == asm_pkg::ADDR_CONFIG) begin
        config_r <= reg_wdata;
      end
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    case (reg_addr)
      asm_pkg::ADDR_ALARM_STATUS: reg_rdata_nxt = status_view;
      asm_pkg::ADDR_ALARM_MASK: reg_rdata_nxt = mask_view;
      asm_pkg::ADDR_CONFIG: reg_rdata_nxt = config_r;
      default: reg_rdata_nxt = 8'h00;
    endcase
  end

  // read data stands one cycle after the strobe only
  always_ff @(posedge clk) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= reg_rdata_nxt;
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // comparator mode looks at live conditions, else at latched bits;
  // busy and diode fault are outside the capable set
  always_comb begin
    if (config_r[asm_pkg::BIT_COMPARATOR]) begin
      alert_src = live & asm_pkg::ALERT_CAPABLE & ~mask_r;
    end else begin
      alert_src = status_r & asm_pkg::ALERT_CAPABLE & ~mask_r;
    end
    // a tach alarm implies the pin is a tach input, so it never drives it
    alert_nxt = (|alert_src[7:1]) && !pin_is_tach;
  end

  // open-drain pin: output value low, enable while asserted
  always_ff @(posedge clk) begin
    if (reset) begin
      alert_n_o <= 1'b0;
      alert_n_oe <= 1'b0;
    end else begin
      alert_n_o <= 1'b0;
      alert_n_oe <= alert_nxt;
    end
  end

  // interrupt sees every unmasked latched alarm, tach included, for polling hosts
  always_ff @(posedge clk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_r & asm_pkg::ALERT_CAPABLE & ~mask_r);
    end
  end

  // assertions
  property p_sticky;
    @(posedge clk) disable iff (reset)
    $rose(status_r[asm_pkg::BIT_REMOTE_HIGH]) && !rd_status |=>
      status_r[asm_pkg::BIT_REMOTE_HIGH] || $past(rd_status);
  endproperty
  a_sticky: assert property (p_sticky) else $error("alarm bit dropped without a read");

  property p_read_clear;
    @(posedge clk) disable iff (reset)
    rd_status && !live[asm_pkg::BIT_LOCAL_HIGH] |=> !status_r[asm_pkg::BIT_LOCAL_HIGH];
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read did not clear gone alarm");

  property p_busy;
    @(posedge clk) disable iff (reset)
    reg_rd && reg_addr == asm_pkg::ADDR_ALARM_STATUS |=> reg_rdata[7] == $past(busy);
  endproperty
  a_busy: assert property (p_busy) else $error("busy bit wrong");

  property p_local;
    @(posedge clk) disable iff (reset)
    (local_temp > local_high) |=> status_r[asm_pkg::BIT_LOCAL_HIGH];
  endproperty
  a_local: assert property (p_local) else $error("local high not latched");

  property p_bit5;
    @(posedge clk) disable iff (reset)
    reg_rd |=> !reg_rdata[asm_pkg::BIT_UNUSED_HI] || $past(reg_addr) != asm_pkg::ADDR_ALARM_STATUS;
  endproperty
  a_bit5: assert property (p_bit5) else $error("status bit 5 not zero");

  property p_crit;
    @(posedge clk) disable iff (reset)
    cond[1] |=> status_r[asm_pkg::BIT_CRIT];
  endproperty
  a_crit: assert property (p_crit) else $error("critical alarm not latched");

  property p_tach_pin;
    @(posedge clk) disable iff (reset)
    pin_is_tach |=> !alert_n_oe;
  endproperty
  a_tach_pin: assert property (p_tach_pin) else $error("alert driven in tach mode");

  property p_mask7;
    @(posedge clk) disable iff (reset)
    reg_rd && reg_addr == asm_pkg::ADDR_ALARM_MASK |=> reg_rdata[7];
  endproperty
  a_mask7: assert property (p_mask7) else $error("mask bit 7 not one");

  property p_masked;
    @(posedge clk) disable iff (reset)
    (&mask_r[6:1]) |=> !alert_n_oe;
  endproperty
  a_masked: assert property (p_masked) else $error("masked alarm reached pin");

  property p_comp;
    @(posedge clk) disable iff (reset)
    config_r[0] && !(|(live & asm_pkg::ALERT_CAPABLE & ~mask_r)) |=> !alert_n_oe;
  endproperty
  a_comp: assert property (p_comp) else $error("comparator alert did not release");

  property p_alert;
    @(posedge clk) disable iff (reset)
    !config_r[0] && status_r[4] && !mask_r[4] && !pin_is_tach |=> alert_n_oe && !alert_n_o;
  endproperty
  a_alert: assert property (p_alert) else $error("alert not asserted");

  // remote high condition must latch one cycle later
  property p_remote_high;
    @(posedge clk) disable iff (reset)
    cond[3] |=> status_r[asm_pkg::BIT_REMOTE_HIGH];
  endproperty
  a_remote_high: assert property (p_remote_high) else $error("remote high not latched");

  // remote low condition must latch one cycle later
  property p_remote_low;
    @(posedge clk) disable iff (reset)
    cond[2] |=> status_r[asm_pkg::BIT_REMOTE_LOW];
  endproperty
  a_remote_low: assert property (p_remote_low) else $error("remote low not latched");

  // slow fan must latch the tach bit
  property p_tach;
    @(posedge clk) disable iff (reset)
    cond[0] |=> status_r[asm_pkg::BIT_TACH];
  endproperty
  a_tach: assert property (p_tach) else $error("tach alarm not latched");

  // synchronised diode fault must latch
  property p_fault;
    @(posedge clk) disable iff (reset)
    diode_fault |=> status_r[asm_pkg::BIT_DIODE_FAULT];
  endproperty
  a_fault: assert property (p_fault) else $error("diode fault not latched");

  // with only fault or nothing latched, neither irq nor latched-mode pin may assert
  property p_fault_quiet;
    @(posedge clk) disable iff (reset)
    !config_r[0] && (status_r & asm_pkg::ALERT_CAPABLE) == 8'h00 |=> !alert_n_oe && !irq;
  endproperty
  a_fault_quiet: assert property (p_fault_quiet) else $error("fault or busy raised alert");

  // busy is shown live and never stored, so it cannot reach the pin
  property p_busy_latch;
    @(posedge clk) disable iff (reset)
    !status_r[asm_pkg::BIT_BUSY];
  endproperty
  a_busy_latch: assert property (p_busy_latch) else $error("busy stored as alarm");

  // unused status bit never stored
  property p_bit5_reg;
    @(posedge clk) disable iff (reset)
    !status_r[asm_pkg::BIT_UNUSED_HI];
  endproperty
  a_bit5_reg: assert property (p_bit5_reg) else $error("status bit 5 stored");

  // a lone tach alarm never drives the pin
  property p_tach_quiet;
    @(posedge clk) disable iff (reset)
    !config_r[0] && (status_r & asm_pkg::ALERT_CAPABLE) == 8'h01 |=> !alert_n_oe;
  endproperty
  a_tach_quiet: assert property (p_tach_quiet) else $error("tach alarm drove pin");

  // unmasked tach alarm is still seen by the interrupt
  property p_tach_irq;
    @(posedge clk) disable iff (reset)
    status_r[asm_pkg::BIT_TACH] && !mask_r[asm_pkg::BIT_TACH] |=> irq;
  endproperty
  a_tach_irq: assert property (p_tach_irq) else $error("tach alarm missed irq");

  // unused mask bits stay set in storage
  property p_mask_fixed;
    @(posedge clk) disable iff (reset)
    (mask_r & asm_pkg::MASK_FORCED_ONE) == asm_pkg::MASK_FORCED_ONE;
  endproperty
  a_mask_fixed: assert property (p_mask_fixed) else $error("unused mask bit cleared");

  // unused mask bits read as one
  property p_mask_read;
    @(posedge clk) disable iff (reset)
    reg_rd && reg_addr == asm_pkg::ADDR_ALARM_MASK |=> reg_rdata[5] && reg_rdata[2];
  endproperty
  a_mask_read: assert property (p_mask_read) else $error("unused mask bits not one");

  // a mask write lands on the next edge
  property p_mask_write;
    @(posedge clk) disable iff (reset)
    reg_wr && reg_addr == asm_pkg::ADDR_ALARM_MASK |=>
      mask_r == ($past(reg_wdata) | asm_pkg::MASK_FORCED_ONE);
  endproperty
  a_mask_write: assert property (p_mask_write) else $error("mask write lost");

  // latched mode: nothing unmasked, pin released
  property p_masked_quiet;
    @(posedge clk) disable iff (reset)
    !config_r[0] && (status_r & asm_pkg::ALERT_CAPABLE & ~mask_r & 8'hFE) == 8'h00 |=>
      !alert_n_oe;
  endproperty
  a_masked_quiet: assert property (p_masked_quiet) else $error("pin held while masked");

  // comparator mode: live unmasked condition other than tach drives the pin when it is not a tach input
  property p_comp_assert;
    @(posedge clk) disable iff (reset)
    config_r[0] && (|(live & asm_pkg::ALERT_CAPABLE & ~mask_r & 8'hFE)) && !pin_is_tach |=>
      alert_n_oe;
  endproperty
  a_comp_assert: assert property (p_comp_assert) else $error("comparator alert missing");

  // outside a status read, bits only gain live conditions
  property p_sticky_all;
    @(posedge clk) disable iff (reset)
    !rd_status |=> status_r == ($past(status_r) | $past(live));
  endproperty
  a_sticky_all: assert property (p_sticky_all) else $error("status changed without read");

  // open-drain value never driven high
  property p_open_drain;
    @(posedge clk) disable iff (reset)
    !alert_n_o;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("alert value driven high");

  // latched mode: any unmasked alert-capable bit other than tach pulls the pin when it is not a tach input
  property p_alert_any;
    @(posedge clk) disable iff (reset)
    !config_r[0] && (|(status_r & asm_pkg::ALERT_CAPABLE & ~mask_r & 8'hFE)) && !pin_is_tach |=>
      alert_n_oe;
  endproperty
  a_alert_any: assert property (p_alert_any) else $error("latched alert missing");
endmodule : asm_alert_status_mask

// *** tb/asm_host_model.sv ***
// Purpose: register-port host that polls and programs the alarm block
// Assumes: one strobe per cycle, read data taken in the cycle after the strobe
// Notes: qualifiers go to the inverse pattern when idle so nothing leans on stale values
`timescale 1ns/1ps
module asm_host_model (
  input wire logic clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata
);
  // idle from time zero: no strobe before reset is over
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // one-cycle write strobe beside address and data
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask : wr
  // read polls a register; the answer stands one cycle only, so take it there
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask : rd
endmodule : asm_host_model

// *** tb/tb_alert_status_mask.sv ***
// Purpose: self-checking bench for the alarm status and mask block
// Assumes: diode fault pin settles within six cycles of the synchroniser
// Notes: idle inputs keep every condition clear; scenarios raise one at a time
`timescale 1ns/1ps
module tb_alert_status_mask;
  logic clk = 1'b0; // 50 MHz system clock
  logic reset = 1'b1; // held for five cycles
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic reg_wr, reg_rd, busy = 0, diode_fault_pin = 0, pin_is_tach = 0;
  logic signed [7:0] local_temp = 0, local_high = 8'h46, critical_limit = 8'h55;
  logic signed [10:0] remote_temp = 0, remote_high = 11'h230, remote_low = 11'h7F8;
  logic [15:0] tach_count = 0, tach_limit = 16'h1000;
  logic alert_n_o, alert_n_oe, irq;
  int n_fail = 0, compares = 0, cycles = 0;
  always #10 clk = ~clk;
  // cycle ceiling stops a hung handshake
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      n_fail = n_fail + 1;
      conclude();
    end
  end
  asm_alert_status_mask i_dut (.clk(clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .busy(busy), .diode_fault_pin(diode_fault_pin), .pin_is_tach(pin_is_tach),
    .local_temp(local_temp), .local_high(local_high), .remote_temp(remote_temp),
    .remote_high(remote_high), .remote_low(remote_low), .critical_limit(critical_limit),
    .tach_count(tach_count), .tach_limit(tach_limit), .alert_n_o(alert_n_o),
    .alert_n_oe(alert_n_oe), .irq(irq));
  asm_host_model i_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  // verdict and end of run
  task automatic conclude();
    if (n_fail == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  // the one comparison point
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // read through the host model and compare
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    i_host.rd(a, d);
    chk(d, exp);
  endtask : rd_chk
  // let n edges pass, then sample settled outputs
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  // every condition back to clear
  task automatic neutral();
    @(posedge clk);
    {local_temp, remote_temp, tach_count, diode_fault_pin} <= '0;
    remote_high <= 11'h230;
  endtask : neutral
  // raised alarm: pin and irq, latched after it goes, cleared by the first read, zero on the second
  task automatic alarm(input int b, input logic al, input logic iq);
    cyc(6);
    chk(alert_n_oe, al);
    chk(irq, iq);
    neutral();
    cyc(6);
    chk(alert_n_oe, al);
    rd_chk(asm_pkg::ADDR_ALARM_STATUS, 8'h01 << b);
    rd_chk(asm_pkg::ADDR_ALARM_STATUS, 8'h00);
    cyc(2);
    chk(irq, 1'b0);
  endtask : alarm
  // reset values, unused bits, unmapped place
  task automatic t_reset();
    chk({alert_n_o, alert_n_oe, irq}, 8'h00);
    rd_chk(asm_pkg::ADDR_ALARM_STATUS, 8'h00);
    rd_chk(asm_pkg::ADDR_ALARM_MASK, 8'hA4);
    rd_chk(8'h55, 8'h00);
    i_host.wr(asm_pkg::ADDR_ALARM_MASK, 8'h00);
    rd_chk(asm_pkg::ADDR_ALARM_MASK, 8'hA4);
    i_host.wr(asm_pkg::ADDR_ALARM_MASK, 8'hFF);
    rd_chk(asm_pkg::ADDR_ALARM_MASK, 8'hFF);
    i_host.wr(asm_pkg::ADDR_ALARM_MASK, 8'h00);
  endtask : t_reset
  // busy shows in bit 7 and never alerts
  task automatic t_busy();
    @(posedge clk) busy <= 1'b1;
    cyc(3);
    rd_chk(asm_pkg::ADDR_ALARM_STATUS, 8'h80);
    chk({alert_n_oe, irq}, 8'h00);
    @(posedge clk) busy <= 1'b0;
  endtask : t_busy
  // equality never alarms, one step past does
  task automatic t_alarms();
    @(posedge clk) {local_temp, remote_temp, tach_count} <= {8'h46, 11'h230, 16'h1000};
    cyc(4);
    rd_chk(asm_pkg::ADDR_ALARM_STATUS, 8'h00);
    @(posedge clk) {remote_temp, remote_high} <= {11'h2A8, 11'h3FF};
    cyc(4);
    rd_chk(asm_pkg::ADDR_ALARM_STATUS, 8'h00);
    @(posedge clk) remote_temp <= 11'h7F8;
    cyc(4);
    rd_chk(asm_pkg::ADDR_ALARM_STATUS, 8'h00);
    neutral();
    @(posedge clk) local_temp <= 8'h47;
    alarm(6, 1'b1, 1'b1);
    @(posedge clk) remote_temp <= 11'h231;
    alarm(4, 1'b1, 1'b1);
    @(posedge clk) remote_temp <= 11'h7F7;
    alarm(3, 1'b1, 1'b1);
    @(posedge clk) {remote_temp, remote_high} <= {11'h2A9, 11'h3FF};
    alarm(1, 1'b1, 1'b1);
    @(posedge clk) diode_fault_pin <= 1'b1;
    alarm(2, 1'b0, 1'b0);
    @(posedge clk) tach_count <= 16'h1001;
    alarm(0, 1'b0, 1'b1);
  endtask : t_alarms
  // masked alarm, tach-configured pin, then comparator mode
  task automatic t_mask_pin();
    i_host.wr(asm_pkg::ADDR_ALARM_MASK, 8'h40);
    @(posedge clk) local_temp <= 8'h47;
    cyc(6);
    chk({alert_n_oe, irq}, 8'h00);
    @(posedge clk) pin_is_tach <= 1'b1;
    i_host.wr(asm_pkg::ADDR_ALARM_MASK, 8'h00);
    cyc(3);
    chk({alert_n_oe, irq}, 8'h01);
    i_host.wr(asm_pkg::ADDR_CONFIG, 8'h01);
    @(posedge clk) pin_is_tach <= 1'b0;
    cyc(3);
    chk(alert_n_oe, 1'b1);
    neutral();
    cyc(3);
    chk({alert_n_oe, irq}, 8'h01);
    rd_chk(asm_pkg::ADDR_ALARM_STATUS, 8'h40);
    i_host.wr(asm_pkg::ADDR_CONFIG, 8'h00);
  endtask : t_mask_pin
  // main sequence
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    cyc(1);
    t_reset();
    t_busy();
    t_alarms();
    t_mask_pin();
    conclude();
  end
endmodule : tb_alert_status_mask
